// file: rtl/adf_pkg.sv
package adf_pkg;

  // ****************************************
  // register offsets (byte addresses)
  // ****************************************
  localparam logic [7:0] ADR_CTRL1 = 8'h00;
  localparam logic [7:0] ADR_CTRL2 = 8'h04;
  localparam logic [7:0] ADR_TRIM = 8'h08;
  localparam logic [7:0] ADR_THRESH = 8'h0C;
  localparam logic [7:0] ADR_IEN = 8'h14;
  localparam logic [7:0] ADR_ISTAT = 8'h18;
  localparam logic [7:0] ADR_IFLAG = 8'h1C;

  // ****************************************
  // field positions
  // ****************************************
  localparam int C1_RUN = 0;
  localparam int C1_FMT = 1;
  localparam int C1_PDWN = 2;
  localparam int C1_DITH = 3;
  localparam int C2_LED_LO = 0;
  localparam int C2_STR_LO = 16;
  localparam int TRIM_OFF_LO = 16;
  localparam int EV_RAW = 0;
  localparam int EV_TRIM = 1;
  localparam int EV_DROP = 2;
  localparam int EV_W = 3;

  // ****************************************
  // values and limits
  // ****************************************
  localparam logic [15:0] GAIN_UNITY = 16'h4000;
  localparam int GAIN_FRAC = 14;
  localparam logic signed [33:0] ROUND_HALF = 34'sh0_0000_2000;
  localparam logic [15:0] OFF_MIN = 16'h8001;
  localparam logic [15:0] OFF_ILLEGAL = 16'h8000;
  localparam logic [15:0] SMP_MAX = 16'h7FFF;
  localparam logic [15:0] SMP_MIN = 16'h8000;
  localparam logic [14:0] THRESH_RST = 15'h7000;
  localparam logic [15:0] STRETCH_RST = 16'h0100;
  // pin stages and memory read ahead of the first real sample after reset
  localparam logic [9:0] FILL_EXTRA = 10'h005;
  localparam int TAP_W = 9;
  localparam int CLK_PERIOD_NS = 40;
  localparam int MAX_CLK_MHZ = 200;

  typedef enum logic [1:0] {LED_RAW, LED_TRIM, LED_EXT, LED_OFF} adf_led_t;

  typedef struct packed {
    logic [15:0] data;
    logic ovld_raw;
    logic ovld_trim;
  } adf_smp_t;

  // magnitude of a signed sample; the most negative code maps to 0x8000
  function automatic logic [15:0] adf_abs(input logic [15:0] x);
    adf_abs = x[15] ? 16'(~x + 16'h0001) : x;
  endfunction

  // clamp a wide signed value to the 16-bit signed range
  function automatic logic [15:0] adf_sat(input logic signed [33:0] v);
    if (v > 34'sh0_0000_7FFF) begin
      adf_sat = SMP_MAX;
    end else if (v < -34'sh0_0000_8000) begin
      adf_sat = SMP_MIN;
    end else begin
      adf_sat = v[15:0];
    end
  endfunction

endpackage

// file: rtl/adf_dly_ram.sv
module adf_dly_ram import adf_pkg::*; (
  // clock
  input wire logic clk,
  // write side
  input wire logic [TAP_W-1:0] waddr,
  input wire logic [15:0] wdata,
  // read side
  input wire logic [TAP_W-1:0] raddr,
  output logic [15:0] rdata
);

  logic [15:0] mem [0:(1<<TAP_W)-1];

  // written every cycle; read returns the older word on an address clash
  always_ff @(posedge clk) begin
    mem[waddr] <= wdata;
  end

  always_ff @(posedge clk) begin
    rdata <= mem[raddr];
  end

endmodule

// file: rtl/adf_front_end.sv
// Contract
// - all registers reached over a 32-bit slave
// - samples leave on a 16-bit stream master
// - order: tap delay, trim, overload, stream
// - trim result is 16-bit signed
// - round product, saturate instead of wrapping
// - tap delay comes from build parameter
// - overload on raw and trimmed, LED shown
// - drive power-down and dither to converter
// - sample path built for 200 MHz
// - interrupt enable, flag and status registers
// - build option for differential termination
// - build option for low power input buffers
// - tap delay accepts 0 to 511
// - LED source codes raw, trim, external, off
// - threshold 0..32767, offset -32767..32767
module adf_front_end import adf_pkg::*; #(
  parameter logic [TAP_W-1:0] TAP_DELAY = 9'h000,
  parameter bit DIFF_TERM = 1'b1,
  parameter bit IBUF_LOW_PWR = 1'b0,
  parameter bit HAS_EXT_LED = 1'b0,
  parameter bit INIT_2COMP = 1'b1,
  parameter bit INIT_PDWN = 1'b0,
  parameter bit INIT_DITHER = 1'b0,
  parameter logic [1:0] INIT_LED_SEL = 2'h0,
  parameter logic [15:0] INIT_GAIN = GAIN_UNITY,
  parameter logic [15:0] INIT_OFFSET = 16'h0000,
  parameter logic [14:0] INIT_THRESH = THRESH_RST,
  parameter logic [15:0] INIT_STRETCH = STRETCH_RST
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register bus
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // converter pins
  input wire logic [15:0] adc_data,
  input wire logic ext_led_src,
  output logic adc_pdwn,
  output logic adc_dither,
  output logic adc_term_en,
  output logic adc_ibuf_low_pwr,
  output logic ovld_led,
  // sample stream
  output logic [15:0] m_axis_tdata,
  output logic m_axis_tvalid,
  input wire logic m_axis_tready
);

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // ****************************************
  // register file
  // ****************************************
  logic [3:0] ctrl1;
  adf_led_t led_sel;
  logic [15:0] stretch;
  logic [15:0] gain;
  logic [15:0] offset;
  logic [14:0] thresh;
  logic [EV_W-1:0] ien;
  logic [EV_W-1:0] iflag;
  logic [EV_W-1:0] ev_set;
  logic [EV_W-1:0] ev_clr;
  logic access;
  logic wr;
  logic hit;
  logic [31:0] next_rdata;

  assign access = psel && penable && !pready;
  assign wr = psel && penable && pready && pwrite && !pslverr;

  always_comb begin
    hit = 1'b1;
    next_rdata = 32'h0000_0000;
    unique case (paddr)
      ADR_CTRL1: next_rdata = {28'h000_0000, ctrl1};
      ADR_CTRL2: next_rdata = {stretch, 14'h0000, led_sel};
      ADR_TRIM: next_rdata = {offset, gain};
      ADR_THRESH: next_rdata = {17'h0_0000, thresh};
      ADR_IEN: next_rdata = {29'h0000_0000, ien};
      ADR_ISTAT: next_rdata = {29'h0000_0000, iflag & ien};
      ADR_IFLAG: next_rdata = {29'h0000_0000, iflag};
      default: hit = 1'b0;
    endcase
  end

  // one wait state: answer on the second access-phase cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= access;
      pslverr <= access && !hit;
      prdata <= (access && !pwrite && hit) ? next_rdata : 32'h0000_0000;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl1 <= {INIT_DITHER, INIT_PDWN, INIT_2COMP, 1'b0};
      led_sel <= adf_led_t'(INIT_LED_SEL);
      stretch <= INIT_STRETCH;
      gain <= INIT_GAIN;
      offset <= INIT_OFFSET;
      thresh <= INIT_THRESH;
      ien <= '0;
    end else if (wr) begin
      unique case (paddr)
        ADR_CTRL1: ctrl1 <= pwdata[3:0];
        ADR_CTRL2: begin
          led_sel <= adf_led_t'(pwdata[C2_LED_LO +: 2]);
          stretch <= pwdata[C2_STR_LO +: 16];
        end
        ADR_TRIM: begin
          gain <= pwdata[15:0];
          // the one code outside the offset range is pulled in
          offset <= (pwdata[TRIM_OFF_LO +: 16] == OFF_ILLEGAL) ? OFF_MIN : pwdata[TRIM_OFF_LO +: 16];
        end
        ADR_THRESH: thresh <= pwdata[14:0];
        ADR_IEN: ien <= pwdata[EV_W-1:0];
        default: ;
      endcase
    end
  end

  assign ev_clr = (wr && paddr == ADR_IFLAG) ? pwdata[EV_W-1:0] : '0;

  // sticky flags, write one to clear; a new event beats the clear
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      iflag <= '0;
    end else begin
      iflag <= (iflag & ~ev_clr) | ev_set;
    end
  end

  // ****************************************
  // converter controls and build options
  // ****************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      adc_pdwn <= INIT_PDWN;
      adc_dither <= INIT_DITHER;
      adc_term_en <= DIFF_TERM;
      adc_ibuf_low_pwr <= IBUF_LOW_PWR;
    end else begin
      adc_pdwn <= ctrl1[C1_PDWN];
      adc_dither <= ctrl1[C1_DITH];
      adc_term_en <= DIFF_TERM;
      adc_ibuf_low_pwr <= IBUF_LOW_PWR;
    end
  end

  // ****************************************
  // pin capture and tap delay
  // ****************************************
  logic [15:0] sy1;
  logic [15:0] sy2;
  logic [15:0] sy3;
  logic [15:0] din;
  logic [2:0] ext_sy;
  logic ext_d;
  logic [TAP_W-1:0] wp;
  logic [TAP_W-1:0] rp;
  logic [15:0] dq;
  logic primed;
  logic [TAP_W:0] fill_cnt;
  logic [15:0] xc;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sy1 <= '0;
      sy2 <= '0;
      sy3 <= '0;
      din <= '0;
      ext_sy <= '0;
      ext_d <= 1'b0;
    end else begin
      sy1 <= adc_data;
      sy2 <= sy1;
      sy3 <= sy2;
      // a bit changes once the second and third stages agree
      din <= ((sy2 ~^ sy3) & sy3) | ((sy2 ^ sy3) & din);
      ext_sy <= {ext_sy[1:0], ext_led_src};
      ext_d <= (ext_sy[1] == ext_sy[2]) ? ext_sy[2] : ext_d;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wp <= '0;
    end else begin
      wp <= wp + 9'h001;
    end
  end

  // the tap count is fixed at build time; 9 bits hold 0..511
  assign rp = wp - TAP_DELAY - 9'h001;

  adf_dly_ram u_dly (
    .clk(clk),
    .waddr(wp),
    .wdata(din),
    .raddr(rp),
    .rdata(dq)
  );

  // hold the trim input at zero until the memory returns real pin samples
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fill_cnt <= '0;
      primed <= 1'b0;
    end else if (!primed) begin
      fill_cnt <= fill_cnt + 10'h001;
      primed <= fill_cnt == {1'b0, TAP_DELAY} + FILL_EXTRA;
    end
  end

  assign xc = primed ? (ctrl1[C1_FMT] ? {~dq[15], dq[14:0]} : dq) : 16'h0000;

  // ****************************************
  // gain, offset, rounding, overload
  // ****************************************
  logic [15:0] x1;
  logic ovr1;
  logic signed [32:0] prod2;
  logic ovr2;
  logic signed [33:0] acc;
  logic [15:0] y3;
  logic ovr3;
  adf_smp_t s4;
  logic v1;
  logic v2;
  logic v3;
  logic v4;

  // offset binary to two's complement by flipping the sign bit
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      x1 <= '0;
      ovr1 <= 1'b0;
    end else begin
      x1 <= xc;
      ovr1 <= adf_abs(xc) > {1'b0, thresh};
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prod2 <= '0;
      ovr2 <= 1'b0;
    end else begin
      // the product has a stage of its own to keep the path short
      prod2 <= $signed(x1) * $signed({1'b0, gain});
      ovr2 <= ovr1;
    end
  end

  assign acc = ((34'(prod2) + ROUND_HALF) >>> GAIN_FRAC) + 34'($signed(offset));

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      y3 <= '0;
      ovr3 <= 1'b0;
    end else begin
      y3 <= adf_sat(acc);
      ovr3 <= ovr2;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s4 <= '0;
    end else begin
      s4.data <= y3;
      s4.ovld_raw <= ovr3;
      s4.ovld_trim <= adf_abs(y3) > {1'b0, thresh};
    end
  end

  // stream valid only once run has followed the whole pipeline
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      {v1, v2, v3, v4} <= 4'h0;
    end else begin
      {v1, v2, v3, v4} <= {ctrl1[C1_RUN], v1, v2, v3};
    end
  end

  // ****************************************
  // two-entry output buffer
  // ****************************************
  logic [15:0] b1;
  logic bv1;
  logic push;
  logic pop;
  logic drop;

  assign push = v4 && !bv1;
  assign drop = v4 && bv1 && !pop;
  assign pop = m_axis_tvalid && m_axis_tready;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      m_axis_tdata <= '0;
      m_axis_tvalid <= 1'b0;
      b1 <= '0;
      bv1 <= 1'b0;
    end else if (pop) begin
      if (bv1) begin
        m_axis_tdata <= b1;
        // the slot freed by the pop takes the arriving sample
        b1 <= s4.data;
        bv1 <= v4;
      end else begin
        m_axis_tdata <= s4.data;
        m_axis_tvalid <= push;
      end
    end else if (push) begin
      if (!m_axis_tvalid) begin
        m_axis_tdata <= s4.data;
        m_axis_tvalid <= 1'b1;
      end else begin
        b1 <= s4.data;
        bv1 <= 1'b1;
      end
    end
  end

  assign ev_set = {drop, s4.ovld_trim, s4.ovld_raw};

  // ****************************************
  // overload LED with stretch
  // ****************************************
  logic led_evt;
  logic [15:0] led_cnt;

  always_comb begin
    unique case (led_sel)
      LED_RAW: led_evt = s4.ovld_raw;
      LED_TRIM: led_evt = s4.ovld_trim;
      LED_EXT: led_evt = HAS_EXT_LED && ext_d;
      LED_OFF: led_evt = 1'b0;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      led_cnt <= '0;
      ovld_led <= 1'b0;
    end else begin
      ovld_led <= led_evt || (led_cnt != 16'h0000);
      if (led_evt) begin
        led_cnt <= stretch;
      end else if (led_cnt != 16'h0000) begin
        led_cnt <= led_cnt - 16'h0001;
      end
    end
  end

  // ****************************************
  // checks
  // ****************************************
  property p_bus_wait;
    psel && penable && !pready |=> pready;
  endproperty
  a_bus_wait: assert property (p_bus_wait) else $error("bus answer not after one wait");

  property p_hold;
    m_axis_tvalid && !m_axis_tready |=> m_axis_tvalid && $stable(m_axis_tdata);
  endproperty
  a_hold: assert property (p_hold) else $error("stream word changed while stalled");

  property p_sat_hi;
    acc > 34'sh0_0000_7FFF |=> y3 == SMP_MAX;
  endproperty
  a_sat_hi: assert property (p_sat_hi) else $error("positive overflow not saturated");

  property p_sat_lo;
    acc < -34'sh0_0000_8000 |=> y3 == SMP_MIN;
  endproperty
  a_sat_lo: assert property (p_sat_lo) else $error("negative overflow not saturated");

  property p_flag;
    s4.ovld_raw |=> iflag[EV_RAW];
  endproperty
  a_flag: assert property (p_flag) else $error("raw overload flag not set");

  property p_led;
    led_evt |=> ovld_led;
  endproperty
  a_led: assert property (p_led) else $error("overload event did not light LED");

  property p_led_off;
    led_sel == LED_OFF && led_cnt == 16'h0000 |=> !ovld_led && led_cnt == 16'h0000;
  endproperty
  a_led_off: assert property (p_led_off) else $error("disabled LED lit");

  property p_pdwn;
    wr && paddr == ADR_CTRL1 |=> ##1 adc_pdwn == $past(pwdata[C1_PDWN], 2);
  endproperty
  a_pdwn: assert property (p_pdwn) else $error("power-down pin does not follow write");

  property p_offset;
    wr && paddr == ADR_TRIM |=> offset != OFF_ILLEGAL;
  endproperty
  a_offset: assert property (p_offset) else $error("offset outside range");

endmodule

// file: sim/adf_conv_model.sv
module adf_conv_model (
  // clock
  input wire logic clk,
  // control from the block
  input wire logic pdwn,
  input wire logic dither,
  // level the bench asks for
  input wire logic [15:0] level,
  // sample pins
  output logic [15:0] adc_data
);
  timeunit 1ns;
  timeprecision 1ps;

  // dither is accepted but leaves the level untouched, so results stay predictable
  initial adc_data = 16'h8000;

  // asleep: pins carry a pattern that changes every cycle
  always @(posedge clk) begin
    adc_data <= pdwn ? ~adc_data : level;
  end
endmodule

// file: sim/tb_top.sv
module tb_top import adf_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [TAP_W-1:0] TAPS = 9'h004;
  logic clk, rst, psel, penable, pwrite, pready, pslverr, ext_led_src, ev;
  logic adc_pdwn, adc_dither, adc_term_en, adc_ibuf_low_pwr, ovld_led;
  logic m_axis_tvalid, m_axis_tready;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rv, t;
  logic [15:0] smp, adc_data, m_axis_tdata, d, g, o;
  logic [31:0] seed = 32'd67;
  logic [47:0] tv [3] = '{{16'hFFFF, 16'hFFFF, 16'h7FFF}, {16'h0000, 16'hFFFF, 16'h8001},
    {16'hC000, 16'h4000, 16'h0000}};
  logic [7:0] ra [6] = '{ADR_CTRL1, ADR_CTRL2, ADR_TRIM, ADR_THRESH, ADR_IEN, ADR_IFLAG};
  logic [31:0] re [6] = '{32'h2, 32'h0100_0000, 32'h4000, 32'h7000, 32'h0, 32'h0};
  int num_errors, checked, n;

  adf_front_end #(.TAP_DELAY(TAPS), .IBUF_LOW_PWR(1'b1), .HAS_EXT_LED(1'b1)) adf_front_end_i (
    .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .adc_data(adc_data),
    .ext_led_src(ext_led_src), .adc_pdwn(adc_pdwn), .adc_dither(adc_dither), .adc_term_en(adc_term_en),
    .adc_ibuf_low_pwr(adc_ibuf_low_pwr), .ovld_led(ovld_led), .m_axis_tdata(m_axis_tdata),
    .m_axis_tvalid(m_axis_tvalid), .m_axis_tready(m_axis_tready));
  adf_conv_model adf_conv_model_i (.clk(clk), .pdwn(adc_pdwn), .dither(adc_dither), .level(smp),
    .adc_data(adc_data));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // ****************************************
  // helpers
  // ****************************************
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic hang(input string nm);
    num_errors++;
    $display("wrong value %s expected answer seen none", nm);
    give_verdict();
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    int k;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) hang("pready");
    rv = prdata;
    ev = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] wd);
    apb(1'b1, a, wd);
  endtask

  task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] e, input logic er);
    apb(1'b0, a, 32'h0);
    chk(nm, rv, e);
    chk("pslverr", 32'(ev), 32'(er));
  endtask

  function logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // reference trim: offset-binary pins, Q2.14 gain, round, add offset, clamp
  function automatic logic [15:0] ref_y(input logic [15:0] pin, input logic [15:0] gn, input logic [15:0] of);
    longint x, gi, y;
    x = longint'($signed(pin ^ 16'h8000));
    gi = longint'(gn);
    y = ((x * gi + 8192) >>> 14) + longint'($signed(of));
    ref_y = y > 32767 ? 16'h7FFF : (y < -32768 ? 16'h8000 : 16'(y));
  endfunction

  task automatic take(input logic [15:0] e);
    repeat (4) begin
      n = 0;
      do begin
        @(posedge clk);
        n++;
      end while (!(m_axis_tvalid === 1'b1 && m_axis_tready === 1'b1) && n < 50);
      if (n >= 50) hang("tvalid");
      chk("tdata", 32'(m_axis_tdata), 32'(e));
    end
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    rst = 1'b1;
    {psel, penable, pwrite, ext_led_src} = 4'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    m_axis_tready = 1'b1;
    smp = 16'h8000;
    repeat (3) @(posedge clk);
    chk("term_en", 32'(adc_term_en), 32'h1);
    chk("ibuf_low_pwr", 32'(adc_ibuf_low_pwr), 32'h1);
    chk("pdwn_dither", 32'({adc_pdwn, adc_dither}), 32'h0);
    chk("tvalid_led", 32'({m_axis_tvalid, ovld_led}), 32'h0);
    rst <= 1'b0;
    for (int i = 0; i < 6; i++) rd("reset_value", ra[i], re[i], 1'b0);
    wr(ADR_CTRL1, 32'h3);
    for (int i = 0; i < 8; i++) begin
      t = rnd();
      {d, g, o} = i < 3 ? tv[i] : {t, 16'(rnd())};
      if (o === OFF_ILLEGAL) o = OFF_MIN;
      wr(ADR_TRIM, {o, g});
      smp <= d;
      repeat (40) @(posedge clk);
      take(ref_y(d, g, o));
    end
    wr(ADR_TRIM, 32'h0000_4000);
    smp <= 16'h8000;
    repeat (40) @(posedge clk);
    smp <= 16'h9000;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (m_axis_tdata !== 16'h1000 && n < 60);
    chk("latency", 32'(n >= TAPS + 10 && n <= TAPS + 13), 32'h1);
    wr(ADR_IFLAG, 32'h7);
    m_axis_tready <= 1'b0;
    repeat (12) begin
      @(posedge clk);
      chk("stall", 32'({m_axis_tvalid, m_axis_tdata}), 32'h1_1000);
    end
    m_axis_tready <= 1'b1;
    rd("drop_flag", ADR_IFLAG, 32'h4, 1'b0);
    wr(ADR_TRIM, 32'h0000_2000);
    smp <= 16'hFF00;
    ext_led_src <= 1'b1;
    for (int s = 0; s < 4; s++) begin
      wr(ADR_CTRL2, {16'h0008, 14'h0, 2'(s)});
      repeat (40) @(posedge clk);
      chk("led", 32'(ovld_led), 32'(s % 2 == 0));
    end
    wr(ADR_IFLAG, 32'h7);
    rd("iflag", ADR_IFLAG, 32'h1, 1'b0);
    wr(ADR_IEN, 32'h2);
    rd("istat", ADR_ISTAT, 32'h0, 1'b0);
    wr(ADR_IEN, 32'h3);
    wr(ADR_ISTAT, 32'h0);
    rd("istat", ADR_ISTAT, 32'h1, 1'b0);
    wr(ADR_TRIM, 32'h0000_4000);
    repeat (40) @(posedge clk);
    rd("iflag_trim", ADR_IFLAG, 32'h3, 1'b0);
    wr(ADR_CTRL2, 32'h0020_0000);
    repeat (40) @(posedge clk);
    smp <= 16'h8000;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ovld_led !== 1'b0 && n < 200);
    // pipeline depth as in the latency check, then 32 stretch cycles
    chk("stretch", 32'(n >= TAPS + 44 && n <= TAPS + 46), 32'h1);
    wr(ADR_CTRL1, 32'hF);
    repeat (2) @(posedge clk);
    chk("pdwn_dither", 32'({adc_pdwn, adc_dither}), 32'h3);
    wr(ADR_CTRL1, 32'h1);
    repeat (2) @(posedge clk);
    chk("pdwn_dither", 32'({adc_pdwn, adc_dither}), 32'h0);
    // no format conversion: pins are already signed
    smp <= 16'h1234;
    repeat (40) @(posedge clk);
    take(ref_y(16'h1234 ^ 16'h8000, 16'h4000, 16'h0000));
    wr(ADR_TRIM, 32'h8000_4000);
    rd("trim", ADR_TRIM, 32'h8001_4000, 1'b0);
    wr(ADR_THRESH, 32'hFFFF_FFFF);
    rd("thresh", ADR_THRESH, 32'h7FFF, 1'b0);
    rd("unmapped", 8'h10, 32'h0, 1'b1);
    rd("unaligned", 8'h02, 32'h0, 1'b1);
    give_verdict();
  end
endmodule
